// >>> hw/rcf_pkg.sv
// What this block does
// R1: Bit 0 of each timer's own enable register turns that timer on (start counting down) or off.
// R2: The select field bits 5:4 give 00 off, and 01/10/11 drive the inverted sense from reference/sensor0/sensor1.
// R3: At most one of the three oscillation networks is active at a time, as the select field picks.
// R4: An enabled drive pin outputs the logical inverse of the sense input, closing the loop.
// R5: A drive pin whose enable is off is left undriven (high impedance).
// R6: While enabled, the fed-back sense clock decrements the value software preloaded into the counter; in stop mode 10 the timer0 base clock does.
// R7: Stop mode bits 7:6 give 00 off, 01 timer2 underflow, 10 one sense cycle, 11 one timer2 clock cycle; reset is off.
// R8: Timer0 alone is 8 bits; one chaining signal adds timer1 for 16 bits, a second adds timer2 for 24 bits in stop modes 00 and 10 only.
// R9: The counter only counts while the internal count window is open.
// R10: A stop signal marks the end of the measurement and halts further counting.
// R11: In every stop mode the end of the measurement raises the timer0 interrupt when bit 2 of interrupt enable is set; mode 00 never stops and raises none.
// R12: Software turns on the drive pin before the counter, then picks a stop mode and enables the timers.
// R13: In stop mode 1 timer2 counts down on its falling clock edges once the window opens and stops at zero.
// R14: In stop mode 2 the first sense falling edge opens the window, the second stops and gates the timer0 clock.
// R15: In stop mode 3 the window between two timer2 clock falling edges enables the sense-clocked counter.
// R16: After the stop the counter holds its final value for software to read back.
package rcf_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_T0_DATA = 8'h00;
	localparam logic [7:0] ADDR_T0_CFG = 8'h01;
	localparam logic [7:0] ADDR_T0_ON = 8'h02;
	localparam logic [7:0] ADDR_T1_DATA = 8'h04;
	localparam logic [7:0] ADDR_T1_CFG = 8'h05;
	localparam logic [7:0] ADDR_T1_ON = 8'h06;
	localparam logic [7:0] ADDR_T2_DATA = 8'h08;
	localparam logic [7:0] ADDR_T2_CFG = 8'h09;
	localparam logic [7:0] ADDR_T2_ON = 8'h0a;
	localparam logic [7:0] ADDR_OSC_SEL = 8'h2f;
	localparam logic [7:0] ADDR_STATUS = 8'h3d;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h3e;
	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int ON_BIT = 0;
	localparam int IE_T0_BIT = 2;
	localparam int OSEL_LO = 4;
	localparam int STOPM_LO = 6;
	localparam logic [7:0] CFG_RST = 8'h1e;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [7:0] ONE8 = 8'h01;
	localparam logic [23:0] ONE24 = 24'h00_0001;
	localparam logic [23:0] MASK8 = 24'h00_00ff;
	localparam logic [23:0] MASK16 = 24'h00_ffff;
	localparam logic [7:0] DIV_ZERO = 8'h00;
	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		OSC_OFF = 2'b00,
		OSC_REF = 2'b01,
		OSC_S0 = 2'b10,
		OSC_S1 = 2'b11
	} rcf_osc_t;
	typedef enum logic [1:0] {
		STOPM_OFF = 2'b00,
		STOPM_T2_UNDER = 2'b01,
		STOPM_SENSE_CYC = 2'b10,
		STOPM_T2_CYC = 2'b11
	} rcf_stopm_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_COUNT = 2'b10,
		ST_DONE = 2'b11
	} rcf_state_t;
endpackage : rcf_pkg

// >>> hw/rcf_top.sv
`timescale 1ns/1ns
`default_nettype none
module rcf_top #(
	parameter logic [7:0] T2_HALF = 8'h14,
	parameter logic [7:0] T0_DIV = 8'h02
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Sense input pin
	input wire logic osc_sense_input,
	// Drive pins
	output logic reference_drive_pin_o,
	output logic reference_drive_pin_oe,
	output logic sensor0_drive_pin_o,
	output logic sensor0_drive_pin_oe,
	output logic sensor1_drive_pin_o,
	output logic sensor1_drive_pin_oe,
	// Status outputs
	output logic count_window_active,
	output logic count_stopped_flag,
	output logic timer0_irq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic sense_s1;
		logic sense_s2;
		logic sense_s3;
		rcf_pkg::rcf_state_t st;
		logic timer0_on;
		logic timer1_on;
		logic timer2_on;
		logic [7:0] timer0_clock_config;
		logic [7:0] timer1_cfg;
		logic [7:0] timer2_cfg;
		logic [1:0] osel;
		logic [7:0] irq_en;
		logic [23:0] cnt;
		logic stopped;
		logic irq;
		logic [7:0] rdata;
		logic drive;
		logic [7:0] t2div;
		logic t2clk;
		logic t2fall;
		logic [7:0] t0div;
		logic t0tick;
	} rcf_state_s_t;

	rcf_state_s_t cur_ff;
	rcf_state_s_t nxt_cur;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [23:0] rcf_dec(input logic [23:0] v, input logic e16,
		input logic e24);
		logic [23:0] d;
		d = v - rcf_pkg::ONE24;
		if (e24) begin
			rcf_dec = d; // R8
		end else if (e16) begin
			rcf_dec = (v & ~rcf_pkg::MASK16) | (d & rcf_pkg::MASK16); // R8
		end else begin
			rcf_dec = (v & ~rcf_pkg::MASK8) | (d & rcf_pkg::MASK8); // R8
		end
	endfunction : rcf_dec

	logic sense_fall;
	logic chain_to_16_bits;
	logic chain_to_24_bits;
	logic timer0_count_clock;
	logic count_ev;
	logic stop_ev;
	logic open_ev;
	rcf_pkg::rcf_stopm_t stopm;

	always_comb begin
		stopm = rcf_pkg::rcf_stopm_t'(cur_ff.timer0_clock_config[rcf_pkg::STOPM_LO +: 2]); // R7
		sense_fall = cur_ff.sense_s3 & ~cur_ff.sense_s2;
		chain_to_16_bits = cur_ff.timer0_on & cur_ff.timer1_on; // R8
		chain_to_24_bits = chain_to_16_bits & cur_ff.timer2_on
			& (stopm == rcf_pkg::STOPM_SENSE_CYC || stopm == rcf_pkg::STOPM_OFF); // R8
		// Timer0 clock is gated off once stopped
		timer0_count_clock = cur_ff.t0tick & (cur_ff.st == rcf_pkg::ST_COUNT); // R14
		open_ev = 1'b0;
		count_ev = 1'b0;
		stop_ev = 1'b0;
		case (stopm)
			rcf_pkg::STOPM_OFF: begin
				open_ev = 1'b1;
				count_ev = sense_fall; // R6
			end
			rcf_pkg::STOPM_T2_UNDER: begin
				open_ev = cur_ff.timer2_on & cur_ff.t2fall; // R13
				count_ev = sense_fall; // R6
				stop_ev = cur_ff.t2fall & (cur_ff.cnt[23:16] <= rcf_pkg::ONE8); // R13
			end
			rcf_pkg::STOPM_SENSE_CYC: begin
				open_ev = sense_fall; // R14
				count_ev = timer0_count_clock; // R14
				stop_ev = sense_fall; // R14
			end
			rcf_pkg::STOPM_T2_CYC: begin
				open_ev = cur_ff.t2fall; // R15
				count_ev = sense_fall; // R15
				stop_ev = cur_ff.t2fall; // R15
			end
			default: begin
				open_ev = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.irq = 1'b0;
		nxt_cur.t2fall = 1'b0;
		nxt_cur.t0tick = 1'b0;
		// Sense synchroniser
		nxt_cur.sense_s1 = osc_sense_input;
		nxt_cur.sense_s2 = cur_ff.sense_s1;
		nxt_cur.sense_s3 = cur_ff.sense_s2;
		// Loop closure: inverse of sense
		nxt_cur.drive = ~cur_ff.sense_s2; // R4
		// Timer2 clock divider
		if (cur_ff.t2div == DIV_LAST(T2_HALF)) begin
			nxt_cur.t2div = rcf_pkg::DIV_ZERO;
			nxt_cur.t2clk = ~cur_ff.t2clk;
			nxt_cur.t2fall = cur_ff.t2clk;
		end else begin
			nxt_cur.t2div = cur_ff.t2div + rcf_pkg::ONE8;
		end
		// Timer0 base clock divider
		if (cur_ff.t0div == DIV_LAST(T0_DIV)) begin
			nxt_cur.t0div = rcf_pkg::DIV_ZERO;
			nxt_cur.t0tick = 1'b1;
		end else begin
			nxt_cur.t0div = cur_ff.t0div + rcf_pkg::ONE8;
		end
		// Measurement sequence
		case (cur_ff.st)
			rcf_pkg::ST_IDLE: begin
				if (cur_ff.timer0_on) begin
					nxt_cur.st = rcf_pkg::ST_ARMED; // R1
				end
			end
			rcf_pkg::ST_ARMED: begin
				if (open_ev) begin
					nxt_cur.st = rcf_pkg::ST_COUNT; // R9
				end
			end
			rcf_pkg::ST_COUNT: begin
				if (stop_ev) begin
					nxt_cur.st = rcf_pkg::ST_DONE; // R10
					nxt_cur.stopped = 1'b1; // R10
					nxt_cur.irq = cur_ff.irq_en[rcf_pkg::IE_T0_BIT]; // R11
					if (stopm == rcf_pkg::STOPM_T2_UNDER) begin
						nxt_cur.cnt[23:16] = rcf_pkg::ZERO8; // R13
					end
				end else begin
					if (count_ev) begin
						nxt_cur.cnt = rcf_dec(cur_ff.cnt, chain_to_16_bits,
							chain_to_24_bits); // R6
					end
					if (stopm == rcf_pkg::STOPM_T2_UNDER && cur_ff.t2fall) begin
						nxt_cur.cnt[23:16] = cur_ff.cnt[23:16] - rcf_pkg::ONE8; // R13
					end
				end
			end
			rcf_pkg::ST_DONE: begin
				nxt_cur.st = rcf_pkg::ST_DONE; // R16
			end
			default: begin
				nxt_cur.st = rcf_pkg::ST_IDLE;
			end
		endcase
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				rcf_pkg::ADDR_T0_DATA: nxt_cur.cnt[7:0] = reg_wdata;
				rcf_pkg::ADDR_T1_DATA: nxt_cur.cnt[15:8] = reg_wdata;
				rcf_pkg::ADDR_T2_DATA: nxt_cur.cnt[23:16] = reg_wdata;
				rcf_pkg::ADDR_T0_CFG: nxt_cur.timer0_clock_config = reg_wdata; // R7
				rcf_pkg::ADDR_T1_CFG: nxt_cur.timer1_cfg = reg_wdata;
				rcf_pkg::ADDR_T2_CFG: nxt_cur.timer2_cfg = reg_wdata;
				rcf_pkg::ADDR_T0_ON: begin
					nxt_cur.timer0_on = reg_wdata[rcf_pkg::ON_BIT]; // R1
					if (~reg_wdata[rcf_pkg::ON_BIT]) begin
						nxt_cur.st = rcf_pkg::ST_IDLE; // R1
					end else if (cur_ff.st == rcf_pkg::ST_DONE) begin
						nxt_cur.st = rcf_pkg::ST_IDLE;
					end
					// A stop in this same cycle still wins
					nxt_cur.stopped = nxt_cur.stopped & (cur_ff.st == rcf_pkg::ST_COUNT);
				end
				rcf_pkg::ADDR_T1_ON: nxt_cur.timer1_on = reg_wdata[rcf_pkg::ON_BIT]; // R1
				rcf_pkg::ADDR_T2_ON: nxt_cur.timer2_on = reg_wdata[rcf_pkg::ON_BIT]; // R1
				rcf_pkg::ADDR_OSC_SEL: nxt_cur.osel = reg_wdata[rcf_pkg::OSEL_LO +: 2]; // R2
				rcf_pkg::ADDR_IRQ_EN: nxt_cur.irq_en = reg_wdata;
				default: nxt_cur.osel = nxt_cur.osel;
			endcase
		end
		// Register reads, data one cycle later
		nxt_cur.rdata = rcf_pkg::ZERO8;
		if (reg_rd) begin
			case (reg_addr)
				rcf_pkg::ADDR_T0_DATA: nxt_cur.rdata = cur_ff.cnt[7:0]; // R16
				rcf_pkg::ADDR_T1_DATA: nxt_cur.rdata = cur_ff.cnt[15:8]; // R16
				rcf_pkg::ADDR_T2_DATA: nxt_cur.rdata = cur_ff.cnt[23:16]; // R16
				rcf_pkg::ADDR_T0_CFG: nxt_cur.rdata = cur_ff.timer0_clock_config;
				rcf_pkg::ADDR_T1_CFG: nxt_cur.rdata = cur_ff.timer1_cfg;
				rcf_pkg::ADDR_T2_CFG: nxt_cur.rdata = cur_ff.timer2_cfg;
				rcf_pkg::ADDR_T0_ON: nxt_cur.rdata = {7'h00, cur_ff.timer0_on};
				rcf_pkg::ADDR_T1_ON: nxt_cur.rdata = {7'h00, cur_ff.timer1_on};
				rcf_pkg::ADDR_T2_ON: nxt_cur.rdata = {7'h00, cur_ff.timer2_on};
				rcf_pkg::ADDR_OSC_SEL: nxt_cur.rdata = {2'h0, cur_ff.osel, 4'h0};
				rcf_pkg::ADDR_IRQ_EN: nxt_cur.rdata = cur_ff.irq_en;
				rcf_pkg::ADDR_STATUS: nxt_cur.rdata = {5'h00, cur_ff.st, cur_ff.stopped};
				default: nxt_cur.rdata = rcf_pkg::ZERO8;
			endcase
		end
	end

	function automatic logic [7:0] DIV_LAST(input logic [7:0] n);
		DIV_LAST = (n == rcf_pkg::DIV_ZERO) ? rcf_pkg::DIV_ZERO : n - rcf_pkg::ONE8;
	endfunction : DIV_LAST

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_ff <= '0;
			cur_ff.st <= rcf_pkg::ST_IDLE;
			cur_ff.timer0_clock_config <= rcf_pkg::CFG_RST; // R7
			cur_ff.timer1_cfg <= rcf_pkg::CFG_RST;
			cur_ff.timer2_cfg <= rcf_pkg::CFG_RST;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reg_rdata = cur_ff.rdata;
	assign reference_drive_pin_o = cur_ff.drive; // R4
	assign sensor0_drive_pin_o = cur_ff.drive; // R4
	assign sensor1_drive_pin_o = cur_ff.drive; // R4
	// One-hot decode leaves all others undriven
	assign reference_drive_pin_oe = (cur_ff.osel == rcf_pkg::OSC_REF); // R3 R5
	assign sensor0_drive_pin_oe = (cur_ff.osel == rcf_pkg::OSC_S0); // R3 R5
	assign sensor1_drive_pin_oe = (cur_ff.osel == rcf_pkg::OSC_S1); // R3 R5
	assign count_window_active = (cur_ff.st == rcf_pkg::ST_COUNT); // R9
	assign count_stopped_flag = cur_ff.stopped; // R10
	assign timer0_irq = cur_ff.irq; // R11
endmodule : rcf_top
`default_nettype wire

// >>> verif/rcf_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rcf_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Pins
	input wire logic osc_sense_input,
	input wire logic reference_drive_pin_o,
	input wire logic reference_drive_pin_oe,
	input wire logic sensor0_drive_pin_o,
	input wire logic sensor0_drive_pin_oe,
	input wire logic sensor1_drive_pin_o,
	input wire logic sensor1_drive_pin_oe,
	// Status
	input wire logic count_window_active,
	input wire logic count_stopped_flag,
	input wire logic timer0_irq
);
	// ------------------------------------------------------------
	// Shadow of the select field and settle counter
	// ------------------------------------------------------------
	logic [1:0] sel_ff;
	logic [2:0] up_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_ff <= 2'b00;
			up_ff <= 3'h0;
		end else begin
			if (reg_wr && reg_addr == rcf_pkg::ADDR_OSC_SEL) begin
				sel_ff <= reg_wdata[5:4];
			end
			if (up_ff != 3'h7) begin
				up_ff <= up_ff + 3'h1;
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	sequence s_abort;
		reg_wr && reg_addr == rcf_pkg::ADDR_T0_ON && !reg_wdata[0];
	endsequence
	sequence s_steady;
		(up_ff == 3'h7 && $stable(osc_sense_input)) [*4];
	endsequence
	property p_sel;
		$stable(sel_ff) |-> {sensor1_drive_pin_oe, sensor0_drive_pin_oe, reference_drive_pin_oe}
			== {sel_ff == 2'b11, sel_ff == 2'b10, sel_ff == 2'b01};
	endproperty
	property p_onehot;
		$onehot0({sensor1_drive_pin_oe, sensor0_drive_pin_oe, reference_drive_pin_oe});
	endproperty
	property p_drive_inv;
		s_steady |-> reference_drive_pin_o == !osc_sense_input
			&& sensor0_drive_pin_o == !osc_sense_input && sensor1_drive_pin_o == !osc_sense_input;
	endproperty
	property p_irq_flag;
		timer0_irq |-> count_stopped_flag && !count_window_active;
	endproperty
	property p_irq_pulse;
		timer0_irq |=> !timer0_irq;
	endproperty
	property p_stop;
		$rose(count_stopped_flag) |-> $past(count_window_active);
	endproperty
	property p_status;
		reg_rd && reg_addr == rcf_pkg::ADDR_STATUS |=> reg_rdata[0] == $past(count_stopped_flag);
	endproperty
	property p_flag_clear;
		$fell(count_stopped_flag) |-> $past(reg_wr && reg_addr == rcf_pkg::ADDR_T0_ON);
	endproperty
	property p_abort;
		s_abort |=> !count_window_active;
	endproperty
	a_sel: assert property (p_sel) else $error("drive enable differs from select field");
	a_onehot: assert property (p_onehot) else $error("more than one drive pin on");
	a_drive_inv: assert property (p_drive_inv) else $error("drive not inverse of sense");
	a_irq_flag: assert property (p_irq_flag) else $error("interrupt without stop");
	a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
	a_stop: assert property (p_stop) else $error("stop without open window");
	a_status: assert property (p_status) else $error("status stop bit wrong");
	a_flag_clear: assert property (p_flag_clear) else $error("stop flag lost");
	a_abort: assert property (p_abort) else $error("window open after timer0 off");
endmodule : rcf_chk
bind rcf_top rcf_chk u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.osc_sense_input, .reference_drive_pin_o, .reference_drive_pin_oe, .sensor0_drive_pin_o,
	.sensor0_drive_pin_oe, .sensor1_drive_pin_o, .sensor1_drive_pin_oe, .count_window_active,
	.count_stopped_flag, .timer0_irq);
`default_nettype wire

// >>> verif/rcf_rc_net.sv
`timescale 1ns/1ns
`default_nettype none
module rcf_rc_net (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Drive pins
	input wire logic [2:0] drv_o,
	input wire logic [2:0] drv_oe,
	// Sense pin
	output logic sense
);
	logic [3:0] wait_ff;
	logic [3:0] dly;
	logic lvl;
	always_comb begin
		dly = drv_oe[0] ? 4'h1 : (drv_oe[1] ? 4'h5 : 4'h9);
		lvl = |(drv_o & drv_oe);
	end
	// Capacitor follows the driven level after a resistor-dependent delay
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sense <= 1'b0;
			wait_ff <= 4'h0;
		end else if (drv_oe == 3'b000 || lvl == sense) begin
			sense <= (drv_oe == 3'b000) ? 1'b0 : sense;
			wait_ff <= dly;
		end else if (wait_ff == 4'h0) begin
			sense <= lvl;
		end else begin
			wait_ff <= wait_ff - 4'h1;
		end
	end
endmodule : rcf_rc_net
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] r;
		logic [2:0] oe;
	} rcf_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic sense;
	wire logic [2:0] drv_o;
	wire logic [2:0] drv_oe;
	logic win;
	logic stp;
	logic irq;
	int err_total = 0;
	int check_count = 0;
	int irq_n = 0;
	logic [7:0] v;
	logic [7:0] w;
	logic [7:0] u;
	logic [1:0] md [4] = '{2'b01, 2'b10, 2'b11, 2'b10};
	logic [7:0] ie [4] = '{8'h04, 8'h04, 8'h04, 8'h00};
	rcf_row_t rows [8] = '{'{8'h2f, 8'h10, 8'h10, 3'b001}, '{8'h2f, 8'h20, 8'h20, 3'b010},
		'{8'h2f, 8'h30, 8'h30, 3'b100}, '{8'h2f, 8'h00, 8'h00, 3'b000}, '{8'h05, 8'h1f, 8'h1f, 3'b000},
		'{8'h06, 8'h01, 8'h01, 3'b000}, '{8'h03, 8'haa, 8'h00, 3'b000}, '{8'h0a, 8'h00, 8'h00, 3'b000}};
	rcf_top #(.T2_HALF(8'h08), .T0_DIV(8'h01)) dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .osc_sense_input(sense), .reference_drive_pin_o(drv_o[0]),
		.reference_drive_pin_oe(drv_oe[0]), .sensor0_drive_pin_o(drv_o[1]),
		.sensor0_drive_pin_oe(drv_oe[1]), .sensor1_drive_pin_o(drv_o[2]),
		.sensor1_drive_pin_oe(drv_oe[2]), .count_window_active(win), .count_stopped_flag(stp),
		.timer0_irq(irq));
	rcf_rc_net net (.clk, .rst_n, .drv_o, .drv_oe, .sense);
	always #50 clk = ~clk;
	always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge clk);
	endtask : rd
	task end_sim;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim
	initial begin
		#2_000_000;
		err_total++;
		end_sim();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		int n;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(rcf_pkg::ADDR_T0_CFG, v);
		chk(24'(v), 24'(rcf_pkg::CFG_RST));
		rd(rcf_pkg::ADDR_T0_ON, v);
		chk(24'(v), 24'h00_0000);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, v);
			chk(24'(v), 24'(rows[i].r));
			chk(24'(drv_oe), 24'(rows[i].oe));
		end
		// Free count, 16-bit chain, stopped by turning timer0 off
		wr(rcf_pkg::ADDR_OSC_SEL, 8'h10);
		wr(rcf_pkg::ADDR_T0_DATA, 8'h02);
		wr(rcf_pkg::ADDR_T1_DATA, 8'h01);
		wr(rcf_pkg::ADDR_T1_ON, 8'h01);
		@(negedge sense);
		repeat (5) @(posedge clk);
		wr(rcf_pkg::ADDR_T0_ON, 8'h01);
		repeat (5) @(negedge sense);
		chk(24'(win), 24'h00_0001);
		repeat (5) @(posedge clk);
		wr(rcf_pkg::ADDR_T0_ON, 8'h00);
		chk(24'(win), 24'h00_0000);
		rd(rcf_pkg::ADDR_T0_DATA, v);
		rd(rcf_pkg::ADDR_T1_DATA, w);
		chk(24'({w, v}), 24'h00_00fd);
		// Full 24-bit chain, one count borrows through all three bytes
		wr(rcf_pkg::ADDR_T0_DATA, 8'h00);
		wr(rcf_pkg::ADDR_T1_DATA, 8'h00);
		wr(rcf_pkg::ADDR_T2_DATA, 8'h01);
		wr(rcf_pkg::ADDR_T2_ON, 8'h01);
		@(negedge sense);
		repeat (5) @(posedge clk);
		wr(rcf_pkg::ADDR_T0_ON, 8'h01);
		@(negedge sense);
		repeat (5) @(posedge clk);
		wr(rcf_pkg::ADDR_T0_ON, 8'h00);
		rd(rcf_pkg::ADDR_T0_DATA, v);
		rd(rcf_pkg::ADDR_T1_DATA, w);
		rd(rcf_pkg::ADDR_T2_DATA, u);
		chk(24'({u, w, v}), 24'h00_ffff);
		wr(rcf_pkg::ADDR_T1_ON, 8'h00);
		// Stop modes 01, 10 and 11 with interrupt on, then 10 with it off
		for (int i = 0; i < 4; i++) begin
			wr(rcf_pkg::ADDR_IRQ_EN, ie[i]);
			wr(rcf_pkg::ADDR_T0_DATA, 8'hff);
			wr(rcf_pkg::ADDR_T2_DATA, 8'h03);
			wr(rcf_pkg::ADDR_T2_ON, {7'h00, md[i] != 2'b10});
			wr(rcf_pkg::ADDR_T0_CFG, {md[i], 6'h1e});
			n = irq_n;
			wr(rcf_pkg::ADDR_T0_ON, 8'h01);
			for (int k = 0; k < 3000 && stp !== 1'b1; k++) @(posedge clk);
			chk(24'(stp), 24'h00_0001);
			repeat (3) @(posedge clk);
			chk(24'(irq_n - n), 24'(ie[i][2]));
			rd(rcf_pkg::ADDR_STATUS, v);
			chk(24'(v), 24'h00_0007);
			rd(rcf_pkg::ADDR_T0_DATA, v);
			chk(24'(v != 8'hff), 24'h00_0001);
			repeat (20) @(posedge clk);
			rd(rcf_pkg::ADDR_T0_DATA, w);
			chk(24'(w), 24'(v));
			rd(rcf_pkg::ADDR_T2_DATA, w);
			if (md[i] == 2'b01) chk(24'(w), 24'h00_0000);
		end
		// Reset in mid-run
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk(24'({stp, drv_oe}), 24'h00_0000);
		rst_n <= 1'b1;
		@(posedge clk);
		end_sim();
	end
endmodule : testbench
`default_nettype wire
